// ==== inc/abc_pkg.sv ====
// Shared constants and types of the address break comparator
package abc_pkg;

  // Register index on the register port
  localparam logic [2:0] ABC_REG_CTRL  = 3'h0;
  localparam logic [2:0] ABC_REG_STAT  = 3'h1;
  localparam logic [2:0] ABC_REG_ADDRH = 3'h2;
  localparam logic [2:0] ABC_REG_ADDRL = 3'h3;
  localparam logic [2:0] ABC_REG_DATAH = 3'h4;
  localparam logic [2:0] ABC_REG_DATAL = 3'h5;

  // Status register fields
  localparam int         ABC_FLAG_BIT  = 7;
  localparam int         ABC_IE_BIT    = 6;
  localparam logic [7:0] ABC_STAT_RSVD = 8'h3f;
  localparam logic       ABC_FLAG_RST  = 1'h0;
  localparam logic       ABC_IE_RST    = 1'h0;

  // Control register fields
  localparam int         ABC_CYC_LSB   = 5;
  localparam int         ABC_ACMP_LSB  = 2;
  localparam int         ABC_DCMP_LSB  = 0;
  localparam logic [7:0] ABC_CTRL_RST  = 8'h00;
  localparam logic [7:0] ABC_CTRL_MASK = 8'h7f;

  localparam logic [15:0] ABC_ADDR_RST = 16'hffff;

  // Compared address width
  localparam logic [2:0] ABC_ACMP_16 = 3'h0;
  localparam logic [2:0] ABC_ACMP_12 = 3'h1;
  localparam logic [2:0] ABC_ACMP_8  = 3'h2;
  localparam logic [2:0] ABC_ACMP_4  = 3'h3;

  // Compared data bytes
  localparam logic [1:0] ABC_DCMP_NONE = 2'h0;
  localparam logic [1:0] ABC_DCMP_LOW  = 2'h1;
  localparam logic [1:0] ABC_DCMP_HIGH = 2'h2;
  localparam logic [1:0] ABC_DCMP_FULL = 2'h3;

  // Cycle kind selection
  localparam logic [1:0] ABC_CYC_FETCH = 2'h0;
  localparam logic [1:0] ABC_CYC_READ  = 2'h1;
  localparam logic [1:0] ABC_CYC_WRITE = 2'h2;
  localparam logic [1:0] ABC_CYC_RW    = 2'h3;

  typedef enum logic [1:0] {
    ABC_SP_ROM  = 2'h0,
    ABC_SP_RAM  = 2'h1,
    ABC_SP_IO8  = 2'h2,
    ABC_SP_IO16 = 2'h3
  } abc_space_e;

  typedef enum logic [1:0] {
    ABC_K_FETCH = 2'h0,
    ABC_K_READ  = 2'h1,
    ABC_K_WRITE = 2'h2,
    ABC_K_IDLE  = 2'h3
  } abc_kind_e;

  typedef enum logic [1:0] {
    ABC_ST_FIRST  = 2'b01,
    ABC_ST_SECOND = 2'b10
  } abc_split_e;

endpackage : abc_pkg

// ==== inc/abc_if.sv ====
// Internal CPU bus and register port between CPU end and break unit
interface abc_if;
  import abc_pkg::*;

  logic        bus_valid;
  logic [15:0] bus_addr;
  logic [15:0] bus_data;
  logic        bus_word;
  abc_space_e  bus_space;
  abc_kind_e   bus_kind;
  logic        reg_wr;
  logic        reg_rd;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        irq;

  modport dev (
    input  bus_valid, bus_addr, bus_data, bus_word, bus_space, bus_kind,
    input  reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, irq
  );

  modport cpu (
    output bus_valid, bus_addr, bus_data, bus_word, bus_space, bus_kind,
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, irq
  );

endinterface : abc_if

// ==== design/abc_break_unit.sv ====
// Address break unit: compares CPU bus cycles with programmed break values
// Function
// RULE_01: Byte access data compared on upper lane.
// RULE_02: Word access: even byte upper, odd lower.
// RULE_03: Eight-bit I/O always uses upper lane.
// RULE_04: Flag bit 7 set on full match.
// RULE_05: Flag clears by zero write after read.
// RULE_06: Bit 6 enables the break interrupt.
// RULE_07: Status bits 5..0 ignore writes, read one.
// RULE_08: Break address is 16 bits, resets ffff.
// RULE_09: Fetch breaks use instruction's first byte address.
// RULE_10: Data high/low bytes match upper/lower lanes.
// RULE_11: Break data unreset; byte data in high.
// RULE_12: Interrupt request while flag and enable set.
// RULE_13: Exception taken after current instruction ends.
// RULE_14: Break request ignores the CPU mask bit.
// RULE_15: Address select picks 16/12/8/4 compared bits.
// RULE_16: Data select: none, low, high, full.
// RULE_17: Word to 8-bit I/O is two bytes.
// RULE_18: With data compare, address and data together.
module abc_break_unit
  import abc_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  abc_if.dev        bus,
  output logic      break_flag_out,
  output logic      break_hit_out
);

  logic [7:0]  ctrl;
  logic        flag;
  logic        ie;
  logic        flag_seen;
  logic [15:0] brk_addr;
  logic [15:0] brk_data;
  logic [7:0]  rdata;
  logic        irq;

  logic [2:0]  acmp;
  logic [1:0]  dcmp;
  logic [1:0]  cyc_sel;
  logic [15:0] addr_mask;
  logic        addr_sel_ok;
  logic        addr_hit;
  logic        upper_only;
  logic        hi_ok;
  logic        lo_ok;
  logic        data_hit;
  logic        cycle_hit;
  logic        hit;
  logic        stat_wr;
  logic        stat_rd;
  logic        flag_clr;
  logic        next_flag;
  logic        next_ie;

  assign acmp    = ctrl[ABC_ACMP_LSB +: 3];
  assign dcmp    = ctrl[ABC_DCMP_LSB +: 2];
  assign cyc_sel = ctrl[ABC_CYC_LSB +: 2];

  // Address width select; reserved codes never match
  always_comb begin
    addr_sel_ok = 1'b1;
    case (acmp)
      ABC_ACMP_16: addr_mask = 16'hffff; // RULE_15
      ABC_ACMP_12: addr_mask = 16'hfff0; // RULE_15
      ABC_ACMP_8:  addr_mask = 16'hff00; // RULE_15
      ABC_ACMP_4:  addr_mask = 16'hf000; // RULE_15
      default: begin
        addr_mask   = 16'h0000;
        addr_sel_ok = 1'b0;
      end
    endcase
  end

  assign addr_hit = addr_sel_ok &&
                    (((bus.bus_addr ^ brk_addr) & addr_mask) == 16'h0000);

  // Byte cycles and any 8-bit I/O cycle carry data on the upper lane only
  assign upper_only = !bus.bus_word || // RULE_01
                      (bus.bus_space == ABC_SP_IO8); // RULE_03 RULE_17

  // Even byte on upper lane, odd byte on lower lane for word cycles
  assign hi_ok = (bus.bus_data[15:8] == brk_data[15:8]); // RULE_10 RULE_02
  assign lo_ok = !upper_only &&
                 (bus.bus_data[7:0] == brk_data[7:0]); // RULE_10 RULE_02

  // Low-only compare cannot match a byte cycle: the lower lane is idle
  always_comb begin
    case (dcmp)
      ABC_DCMP_NONE: data_hit = 1'b1; // RULE_16
      ABC_DCMP_LOW:  data_hit = lo_ok; // RULE_16
      ABC_DCMP_HIGH: data_hit = hi_ok; // RULE_16
      ABC_DCMP_FULL: data_hit = hi_ok && (upper_only || lo_ok); // RULE_16
      default:       data_hit = 1'b0;
    endcase
  end

  always_comb begin
    case (cyc_sel)
      ABC_CYC_FETCH: cycle_hit = (bus.bus_kind == ABC_K_FETCH);
      ABC_CYC_READ:  cycle_hit = (bus.bus_kind == ABC_K_READ);
      ABC_CYC_WRITE: cycle_hit = (bus.bus_kind == ABC_K_WRITE);
      ABC_CYC_RW:    cycle_hit = (bus.bus_kind == ABC_K_READ) ||
                                 (bus.bus_kind == ABC_K_WRITE);
      default:       cycle_hit = 1'b0;
    endcase
  end

  // Address and data must hit in the same bus cycle
  assign hit = bus.bus_valid && addr_hit && data_hit && cycle_hit; // RULE_18

  assign stat_wr = bus.reg_wr && (bus.reg_addr == ABC_REG_STAT);
  assign stat_rd = bus.reg_rd && (bus.reg_addr == ABC_REG_STAT);

  // Only a zero write after reading the flag as one clears it
  assign flag_clr = stat_wr && flag_seen &&
                    !bus.reg_wdata[ABC_FLAG_BIT]; // RULE_05

  // A hit in the clearing cycle wins
  assign next_flag = hit || (flag && !flag_clr); // RULE_04
  assign next_ie   = stat_wr ? bus.reg_wdata[ABC_IE_BIT] : ie; // RULE_06

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      flag <= ABC_FLAG_RST;
    end else begin
      flag <= next_flag; // RULE_04
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ie <= ABC_IE_RST;
    end else begin
      ie <= next_ie; // RULE_06
    end
  end

  // Read of flag as one arms the clear; any status write disarms it
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      flag_seen <= 1'b0;
    end else if (stat_wr) begin
      flag_seen <= 1'b0; // RULE_05
    end else if (stat_rd && flag) begin
      flag_seen <= 1'b1; // RULE_05
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctrl <= ABC_CTRL_RST;
    end else if (bus.reg_wr && (bus.reg_addr == ABC_REG_CTRL)) begin
      ctrl <= bus.reg_wdata & ABC_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      brk_addr <= ABC_ADDR_RST; // RULE_08
    end else if (bus.reg_wr && (bus.reg_addr == ABC_REG_ADDRH)) begin
      brk_addr[15:8] <= bus.reg_wdata; // RULE_08
    end else if (bus.reg_wr && (bus.reg_addr == ABC_REG_ADDRL)) begin
      brk_addr[7:0] <= bus.reg_wdata; // RULE_08
    end
  end

  // Left unreset on purpose: software loads it before use
  always_ff @(posedge ref_clk_in) begin
    if (bus.reg_wr && (bus.reg_addr == ABC_REG_DATAH)) begin
      brk_data[15:8] <= bus.reg_wdata; // RULE_11
    end else if (bus.reg_wr && (bus.reg_addr == ABC_REG_DATAL)) begin
      brk_data[7:0] <= bus.reg_wdata; // RULE_11
    end
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata <= 8'h00;
    end else if (bus.reg_rd) begin
      case (bus.reg_addr)
        ABC_REG_CTRL:  rdata <= ctrl;
        ABC_REG_STAT:  rdata <= {flag, ie, ABC_STAT_RSVD[5:0]}; // RULE_07
        ABC_REG_ADDRH: rdata <= brk_addr[15:8];
        ABC_REG_ADDRL: rdata <= brk_addr[7:0];
        ABC_REG_DATAH: rdata <= brk_data[15:8];
        ABC_REG_DATAL: rdata <= brk_data[7:0];
        default:       rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Registered from next values so the request tracks flag and enable
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      irq <= 1'b0;
    end else begin
      irq <= next_flag && next_ie; // RULE_12
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      break_hit_out <= 1'b0;
    end else begin
      break_hit_out <= hit;
    end
  end

  assign bus.reg_rdata   = rdata;
  assign bus.irq         = irq;
  assign break_flag_out  = flag;

endmodule : abc_break_unit

// ==== design/abc_cpu_end.sv ====
// CPU end: drives bus cycles and register port, takes break exceptions
module abc_cpu_end
  import abc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  abc_if.cpu               bus,
  input  wire logic        cyc_req_in,
  input  wire logic [15:0] cyc_addr_in,
  input  wire logic [15:0] cyc_data_in,
  input  wire logic        cyc_word_in,
  input  wire logic [1:0]  cyc_space_in,
  input  wire logic [1:0]  cyc_kind_in,
  input  wire logic        instr_done_in,
  input  wire logic        ccr_i_mask_in,
  input  wire logic        ext_irq_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic             busy_out,
  output logic [7:0]       reg_rdata_out,
  output logic             break_exc_out,
  output logic             ext_exc_out
);

  abc_split_e  state;
  logic        valid;
  logic [15:0] addr;
  logic [15:0] data;
  logic        word;
  abc_space_e  space;
  abc_kind_e   kind;
  logic [15:0] second_addr;
  logic [7:0]  second_byte;
  logic        rd_d;
  logic        split;

  // Word to 8-bit I/O goes out as two byte cycles, upper lane each
  assign split = cyc_req_in && cyc_word_in &&
                 (abc_space_e'(cyc_space_in) == ABC_SP_IO8); // RULE_17

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state       <= ABC_ST_FIRST;
      valid       <= 1'b0;
      addr        <= 16'h0000;
      data        <= 16'h0000;
      word        <= 1'b0;
      space       <= ABC_SP_ROM;
      kind        <= ABC_K_IDLE;
      second_addr <= 16'h0000;
      second_byte <= 8'h00;
    end else begin
      case (state)
        ABC_ST_FIRST: begin
          // Fetch address is the instruction's first byte
          valid <= cyc_req_in; // RULE_09
          addr  <= cyc_addr_in;
          data  <= cyc_data_in;
          word  <= cyc_word_in && !split;
          space <= abc_space_e'(cyc_space_in);
          kind  <= cyc_req_in ? abc_kind_e'(cyc_kind_in) : ABC_K_IDLE;
          if (split) begin
            second_addr <= cyc_addr_in + 16'h0001;
            second_byte <= cyc_data_in[7:0];
            state       <= ABC_ST_SECOND;
          end
        end
        ABC_ST_SECOND: begin
          valid <= 1'b1;
          addr  <= second_addr;
          data  <= {second_byte, 8'h00}; // RULE_17
          word  <= 1'b0;
          state <= ABC_ST_FIRST;
        end
        default: begin
          valid <= 1'b0;
          kind  <= ABC_K_IDLE;
          state <= ABC_ST_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_addr  <= 3'h0;
      bus.reg_wdata <= 8'h00;
      rd_d          <= 1'b0;
      reg_rdata_out <= 8'h00;
    end else begin
      bus.reg_wr    <= reg_wr_in;
      bus.reg_rd    <= reg_rd_in;
      bus.reg_addr  <= reg_addr_in;
      bus.reg_wdata <= reg_wdata_in;
      rd_d          <= bus.reg_rd;
      reg_rdata_out <= rd_d ? bus.reg_rdata : 8'h00;
    end
  end

  // Exceptions only at instruction end; break ignores the mask bit
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      break_exc_out <= 1'b0;
      ext_exc_out   <= 1'b0;
    end else begin
      break_exc_out <= instr_done_in && bus.irq; // RULE_13 RULE_14
      ext_exc_out   <= instr_done_in && ext_irq_in && !ccr_i_mask_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state == ABC_ST_FIRST) && split;
    end
  end

  assign bus.bus_valid = valid;
  assign bus.bus_addr  = addr;
  assign bus.bus_data  = data;
  assign bus.bus_word  = word;
  assign bus.bus_space = space;
  assign bus.bus_kind  = kind;

endmodule : abc_cpu_end

// ==== tb/abc_chk.sv ====
// Checker on the CPU bus and register port of the break unit
module abc_chk
  import abc_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       srst_in,
  input wire logic       bus_valid,
  input wire abc_space_e bus_space,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // Shadow of the plain registers; break data stays unknown until written
  logic [7:0] shd [8];
  logic [7:0] known;
  logic [7:0] rd_exp;
  wire        st_wr = reg_wr && reg_addr == ABC_REG_STAT;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      shd   <= '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
      known <= 8'hcd;
    end else if (reg_wr && reg_addr > ABC_REG_STAT && reg_addr < 3'h6) begin
      shd[reg_addr]   <= reg_wdata;
      known[reg_addr] <= 1'b1;
    end else if (reg_wr && reg_addr == ABC_REG_CTRL) begin
      shd[0] <= reg_wdata & ABC_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    rd_exp <= shd[reg_addr];
  end

  a_rsvd_ones: assert property (reg_rd && reg_addr == ABC_REG_STAT
    |=> reg_rdata[5:0] == 6'h3f) else $error("reserved bits not one");
  a_status_irq: assert property (reg_rd && reg_addr == ABC_REG_STAT
    |=> (reg_rdata[7] & reg_rdata[6]) == $past(irq))
    else $error("irq differs from flag and enable");
  a_ctrl_readback: assert property (reg_rd && reg_addr == 3'h0
    |=> reg_rdata == rd_exp) else $error("control readback wrong");
  a_break_readback: assert property (reg_rd && reg_addr > 3'h1
    && known[reg_addr] |=> reg_rdata == rd_exp)
    else $error("break register readback wrong");
  a_irq_cause: assert property ($rose(irq)
    |-> $past(bus_valid) || $past(st_wr)) else $error("irq rose unprompted");
  a_irq_fall: assert property ($fell(irq)
    |-> $past(st_wr) || $past(srst_in)) else $error("irq fell unprompted");
  a_ie_gate: assert property (st_wr && !reg_wdata[ABC_IE_BIT]
    |=> !irq) else $error("irq high with enable clear");
  a_flag_sticky: assert property (irq && !st_wr
    |=> irq) else $error("irq dropped without status write");

  c_irq: cover property ($rose(irq));
  c_clear: cover property ($fell(irq));
  c_split: cover property (bus_valid && bus_space == ABC_SP_IO8 ##1 bus_valid);
endmodule : abc_chk

// ==== tb/test_address_break_comparator.sv ====
// Bench joining the break unit and the CPU end over the CPU bus
module test_address_break_comparator import abc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Row: ctrl, break address, address, data, word, space/kind, hit
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] ba, a, d;
    logic [3:0]  w;
    logic [1:0]  sp, k;
    logic [3:0]  hit;
  } abc_row_s;
  localparam abc_row_s rows [18] = '{
    68'h00_1234_1234_0000_0_0_1, 68'h00_1234_1235_0000_0_0_0,
    68'h04_1234_123f_0000_0_0_1, 68'h08_1234_12ff_0000_0_0_1,
    68'h0c_1234_1fff_0000_0_0_1, 68'h0c_1234_2234_0000_0_0_0,
    68'h10_1234_1234_0000_0_0_0, 68'h23_1234_1234_abcd_1_5_1,
    68'h23_1234_1234_abce_1_5_0, 68'h22_1235_1235_ab00_0_5_1,
    68'h22_1235_1235_00ab_0_5_0, 68'h21_1234_1234_00cd_1_5_1,
    68'h40_1234_1234_0000_0_5_0, 68'h40_1234_1234_0000_0_6_1,
    68'h60_1234_1234_0000_0_5_1, 68'h23_1234_1234_abcd_1_d_1,
    68'h22_1235_1234_cdab_1_9_1, 68'h23_1235_1235_ab00_0_5_1};
  logic        ref_clk_in, srst_in, req, w, done, mask, xirq, rwr, rrd;
  logic [15:0] a, d;
  logic [1:0]  sp, k;
  logic [2:0]  ra;
  logic [7:0]  wd, rdo, v;
  logic        busy, bexc, xexc, flag, hit, h, busy_seen;
  int          bad_count = 0;
  int          samples_checked = 0;

  abc_if bus ();
  abc_break_unit u_abc_break_unit (.ref_clk_in, .srst_in, .bus,
    .break_flag_out(flag), .break_hit_out(hit));
  abc_cpu_end u_abc_cpu_end (.ref_clk_in, .srst_in, .bus, .cyc_req_in(req),
    .cyc_addr_in(a), .cyc_data_in(d), .cyc_word_in(w), .cyc_space_in(sp),
    .cyc_kind_in(k), .instr_done_in(done), .ccr_i_mask_in(mask),
    .ext_irq_in(xirq), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_addr_in(ra),
    .reg_wdata_in(wd), .busy_out(busy), .reg_rdata_out(rdo),
    .break_exc_out(bexc), .ext_exc_out(xexc));
  abc_chk u_abc_chk (.ref_clk_in, .srst_in, .bus_valid(bus.bus_valid),
    .bus_space(bus.bus_space), .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd),
    .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
    .reg_rdata(bus.reg_rdata), .irq(bus.irq));

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Ends just after the edge on which the device took the write, so effects are visible
  task automatic wr(input logic [2:0] ad, input logic [7:0] dv);
    @(posedge ref_clk_in);
    rwr <= 1'b1;
    ra <= ad;
    wd <= dv;
    @(posedge ref_clk_in);
    rwr <= 1'b0;
    @(posedge ref_clk_in);
    #1;
  endtask : wr

  // Read data reach the user side three cycles after the strobe
  task automatic rd(input logic [2:0] ad);
    @(posedge ref_clk_in);
    rrd <= 1'b1;
    ra <= ad;
    @(posedge ref_clk_in);
    rrd <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 v = rdo;
  endtask : rd

  // Watches two cycles, as a split word hits on its second byte
  task automatic cyc(input abc_row_s r);
    @(posedge ref_clk_in);
    req <= 1'b1;
    {a, d, w, sp, k} <= {r.a, r.d, r.w[0], r.sp, r.k};
    @(posedge ref_clk_in);
    req <= 1'b0;
    #1 busy_seen = busy;
    @(posedge ref_clk_in);
    #1 h = hit;
    @(posedge ref_clk_in);
    #1 h = h | hit;
  endtask : cyc

  task automatic complete_run;
    $display("Mismatches %0d, checks %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    #1_000_000;
    bad_count++;
    complete_run();
  end

  initial begin
    {req, w, done, mask, xirq, rwr, rrd} = '0;
    {a, d, sp, k, ra, wd} = '0;
    srst_in = 1'b1;
    repeat (12) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rd(ABC_REG_STAT);
    cmp(v, 8'h3f);
    rd(ABC_REG_ADDRH);
    cmp(v, 8'hff);
    rd(ABC_REG_CTRL);
    cmp(v, 8'h00);
    wr(ABC_REG_STAT, 8'hff);
    rd(ABC_REG_STAT);
    cmp(v, 8'h7f);
    wr(3'h7, 8'h5a);
    rd(3'h7);
    cmp(v, 8'h00);
    wr(ABC_REG_STAT, 8'h00);
    wr(ABC_REG_DATAH, 8'hab);
    wr(ABC_REG_DATAL, 8'hcd);
    foreach (rows[i]) begin
      wr(ABC_REG_CTRL, rows[i].ctrl);
      wr(ABC_REG_ADDRH, rows[i].ba[15:8]);
      wr(ABC_REG_ADDRL, rows[i].ba[7:0]);
      cyc(rows[i]);
      cmp(8'(h), 8'(rows[i].hit));
      cmp(8'(flag), 8'(rows[i].hit));
      cmp(8'(busy_seen),
        8'(rows[i].w[0] && rows[i].sp == ABC_SP_IO8));
      rd(ABC_REG_STAT);
      wr(ABC_REG_STAT, 8'h00);
    end
    // Flag held while enable toggles; exception ignores the mask
    wr(ABC_REG_ADDRL, 8'h34);
    wr(ABC_REG_CTRL, 8'h00);
    wr(ABC_REG_STAT, 8'h40);
    cyc(rows[0]);
    cmp(8'(bus.irq), 8'h01);
    wr(ABC_REG_STAT, 8'h40);
    cmp(8'(flag), 8'h01);
    @(posedge ref_clk_in);
    mask <= 1'b1;
    xirq <= 1'b1;
    done <= 1'b1;
    @(posedge ref_clk_in);
    done <= 1'b0;
    #1 cmp(8'({bexc, xexc}), 8'h02);
    @(posedge ref_clk_in);
    mask <= 1'b0;
    #1 cmp(8'({bexc, xexc}), 8'h00);
    @(posedge ref_clk_in);
    done <= 1'b1;
    @(posedge ref_clk_in);
    done <= 1'b0;
    #1 cmp(8'({bexc, xexc}), 8'h03);
    wr(ABC_REG_STAT, 8'h00);
    cmp(8'({bus.irq, flag}), 8'h01);
    rd(ABC_REG_STAT);
    cmp(v, 8'hbf);
    wr(ABC_REG_STAT, 8'h00);
    cmp(8'(flag), 8'h00);
    // Reset in mid-run drops a set flag and restores the address
    wr(ABC_REG_STAT, 8'h40);
    cyc(rows[0]);
    cmp(8'({bus.irq, flag}), 8'h03);
    wr(ABC_REG_ADDRL, 8'h00);
    @(posedge ref_clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rd(ABC_REG_ADDRL);
    cmp(v, 8'hff);
    cmp(8'({bus.irq, flag}), 8'h00);
    complete_run();
  end
endmodule : test_address_break_comparator
